//--- ahb_bridge_cfg.svh
// address map and protocol encodings for the north-to-south bridge
`ifndef AHB_BRIDGE_CFG_SVH
`define AHB_BRIDGE_CFG_SVH

// ahb transfer types
`define HTRANS_IDLE   2'h0
`define HTRANS_NONSEQ 2'h2

// ahb responses
`define HRESP_OKAY  2'h0
`define HRESP_ERROR 2'h1
`define HRESP_RETRY 2'h2
`define HRESP_SPLIT 2'h3

// single word transfers only
`define HSIZE_WORD    3'h2
`define HBURST_SINGLE 3'h0

// region field of an address
`define REGION_MSB 31
`define REGION_LSB 28

// region codes
`define REG_SDRAM 4'h0
`define REG_PCI   4'h4
`define REG_EXP   4'h5
`define REG_QMGR  4'h6
`define REG_APB   4'hc

// apb target index field
`define APB_SEL_MSB 14
`define APB_SEL_LSB 12
`define APB_SEL_ONE 8'h01
`define APB_SEL_NONE 8'h00

`endif

//--- ahb_bridge_pkg.sv
// types shared by the north-to-south bridge
package ahb_bridge_pkg;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_REQ  = 2'b01,
		S_ADDR = 2'b10,
		S_DATA = 2'b11
	} south_state_t;

	typedef enum logic [1:0] {
		RP_OKAY   = 2'b00,
		RP_FIRST  = 2'b01,
		RP_SECOND = 2'b10
	} resp_phase_t;

	typedef enum logic {
		NT_SDRAM  = 1'b0,
		NT_BRIDGE = 1'b1
	} north_target_t;

	typedef enum logic [2:0] {
		ST_SDRAM = 3'b000,
		ST_PCI   = 3'b001,
		ST_QMGR  = 3'b010,
		ST_EXP   = 3'b011,
		ST_APB   = 3'b100,
		ST_NONE  = 3'b111
	} south_target_t;

endpackage : ahb_bridge_pkg

//--- ahb_post_split_bridge.sv
// north-to-south ahb bridge with posted writes and split reads
//
// Operation
// - north segment is a 32-bit ahb; only packet engines master it.
// - north decode has two targets: sdram and this bridge.
// - north writes are posted, north reads are split.
// - a write is queued only with a free slot; queuing ends it north.
// - a queued write runs south as soon as the south bus is won.
// - after posting a write the north bus is released at once.
// - a read is queued only with a free slot, then answered split.
// - each queued read runs south when granted; its data is held.
// - held read data raises the split-done line of its master.
// - other masters use the north bus while a split read waits.
// - south segment is a 32-bit ahb; the bridge is one master.
// - south decode has sdram, pci, queue manager, expansion, apb.
// - apb is 32 bits, only mastered by the ahb-to-apb bridge.
// - apb decodes uarts, usb, monitor, gpio, engines, irq, timers.
// - apb gives a second path into each packet engine.
// - sdram bursts are at most eight words; bridge issues singles.
`timescale 1ns/10ps
`default_nettype none
`include "ahb_bridge_cfg.svh"

module ahb_post_split_bridge #(
	parameter int DW    = 32,
	parameter int AW    = 32,
	parameter int DEPTH = 4,
	parameter int NM    = 16,
	parameter int MIDW  = 4
) (
	// clock and reset
	input  wire logic                          clk_sys_i,
	input  wire logic                          rst_n_i,
	// north ahb slave side
	input  wire logic [AW-1:0]                 n_haddr_i,
	input  wire logic [1:0]                    n_htrans_i,
	input  wire logic                          n_hwrite_i,
	input  wire logic [DW-1:0]                 n_hwdata_i,
	input  wire logic [MIDW-1:0]               n_hmaster_i,
	input  wire logic                          n_hready_i,
	output var  logic                          n_hready_o,
	output var  logic [1:0]                    n_hresp_o,
	output var  logic [DW-1:0]                 n_hrdata_o,
	output var  logic [NM-1:0]                 n_hsplit_o,
	output var  ahb_bridge_pkg::north_target_t n_dsel_o,
	// south ahb master side
	input  wire logic                          s_hgrant_i,
	input  wire logic                          s_hready_i,
	input  wire logic [1:0]                    s_hresp_i,
	input  wire logic [DW-1:0]                 s_hrdata_i,
	output var  logic                          s_hbusreq_o,
	output var  logic [1:0]                    s_htrans_o,
	output var  logic [AW-1:0]                 s_haddr_o,
	output var  logic                          s_hwrite_o,
	output var  logic [DW-1:0]                 s_hwdata_o,
	output var  logic [2:0]                    s_hsize_o,
	output var  logic [2:0]                    s_hburst_o,
	output var  ahb_bridge_pkg::south_target_t s_target_o,
	output var  logic [7:0]                    apb_sel_o
);
	import ahb_bridge_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam int EW = 1 + MIDW + AW + DW;

	// queue storage
	logic [EW-1:0]   fifo_mem [DEPTH];
	logic [PW-1:0]   wr_ptr_reg;
	logic [PW-1:0]   rd_ptr_reg;
	logic [PW:0]     count_reg;
	logic [PW:0]     count_next;
	logic            push_pend_reg;
	logic [MIDW+AW:0] pend_reg;

	// per-master split state
	logic [NM-1:0]   outst_reg;
	logic [NM-1:0]   held_vld_reg;
	logic [DW-1:0]   held_data_reg [NM];

	// response phase
	resp_phase_t     rp_reg;
	resp_phase_t     rp_next;

	// south sequencer
	south_state_t    st_reg;
	south_state_t    st_next;

	// north address-phase decode
	wire [3:0] n_region   = n_haddr_i[`REGION_MSB:`REGION_LSB];
	wire       n_is_bridge = n_region != `REG_SDRAM;
	wire       n_addr_ph   = n_htrans_i[1] & n_hready_i;
	wire       n_take      = n_addr_ph & n_is_bridge;
	wire       space       = (count_reg + {{PW{1'b0}}, push_pend_reg}) < (PW+1)'(DEPTH);
	wire       held_hit    = held_vld_reg[n_hmaster_i];
	wire       waiting     = outst_reg[n_hmaster_i];
	wire [DW-1:0] held_sel = held_data_reg[n_hmaster_i];

	// a reissued read collects held data
	wire ok_rd    = n_take & ~n_hwrite_i & held_hit;
	wire do_split = n_take & ~n_hwrite_i & ~held_hit & (waiting | space);
	wire do_retry = n_take & ~ok_rd & ~do_split & ~space;
	// queue only into a free slot
	wire do_push  = n_take & space & (n_hwrite_i | (~held_hit & ~waiting));

	// queue head fields
	wire [EW-1:0]   head     = fifo_mem[rd_ptr_reg];
	wire            head_wr  = head[EW-1];
	wire [MIDW-1:0] head_mst = head[EW-2 -: MIDW];
	wire [AW-1:0]   head_addr = head[DW +: AW];
	wire [DW-1:0]   head_data = head[DW-1:0];
	wire            fifo_empty = count_reg == '0;

	// south completion
	wire s_resp_end = (s_hresp_i == `HRESP_OKAY) | (s_hresp_i == `HRESP_ERROR);
	wire xfer_done  = (st_reg == S_DATA) & s_hready_i & s_resp_end;
	wire rd_done    = xfer_done & ~head_wr;
	wire s_load     = (st_reg == S_REQ) & s_hgrant_i & s_hready_i;

	wire [3:0] s_region = head_addr[`REGION_MSB:`REGION_LSB];
	south_target_t s_tgt_w;
	assign s_tgt_w = (s_region == `REG_SDRAM) ? ST_SDRAM :
			(s_region == `REG_PCI)  ? ST_PCI  :
			(s_region == `REG_QMGR) ? ST_QMGR :
			(s_region == `REG_EXP)  ? ST_EXP  :
			(s_region == `REG_APB)  ? ST_APB  : ST_NONE;

	// apb targets 0 to 7 are uarts, usb, monitor, gpio, engines, irq, timers
	// the packet_engine index gives the second access path
	wire [2:0] apb_idx = head_addr[`APB_SEL_MSB:`APB_SEL_LSB];
	// apb reached only through its bridge
	wire [7:0] apb_sel_w = (s_tgt_w == ST_APB) ? (`APB_SEL_ONE << apb_idx) : `APB_SEL_NONE;

	// response phase sequencing
	always_comb begin
		unique case (rp_reg)
			RP_FIRST: rp_next = RP_SECOND;
			RP_OKAY, RP_SECOND: rp_next = (do_split | do_retry) ? RP_FIRST : RP_OKAY;
			default: rp_next = RP_OKAY;
		endcase
	end

	// posted write answered okay with no wait
	// split and retry release the north bus
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rp_reg     <= RP_OKAY;
			n_hready_o <= 1'b1;
			n_hresp_o  <= `HRESP_OKAY;
			n_hrdata_o <= '0;
			n_dsel_o   <= NT_SDRAM;
		end else begin
			rp_reg     <= rp_next;
			n_hready_o <= rp_next != RP_FIRST;
			if (rp_next == RP_OKAY)
				n_hresp_o <= `HRESP_OKAY;
			else if (rp_reg != RP_FIRST)
				n_hresp_o <= do_split ? `HRESP_SPLIT : `HRESP_RETRY;
			n_hrdata_o <= ok_rd ? held_sel : '0;
			if (n_addr_ph)
				n_dsel_o <= n_is_bridge ? NT_BRIDGE : NT_SDRAM;
		end
	end

	// queue write one cycle after the address phase
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			push_pend_reg <= 1'b0;
			pend_reg      <= '0;
		end else begin
			push_pend_reg <= do_push;
			if (do_push)
				pend_reg <= {n_hwrite_i, n_hmaster_i, n_haddr_i};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (push_pend_reg)
			fifo_mem[wr_ptr_reg] <= {pend_reg, n_hwdata_i};
	end

	assign count_next = count_reg + {{PW{1'b0}}, push_pend_reg} - {{PW{1'b0}}, xfer_done};

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + PW'(push_pend_reg);
			rd_ptr_reg <= rd_ptr_reg + PW'(xfer_done);
			count_reg  <= count_next;
		end
	end

	// per-master split bookkeeping
	genvar m;
	generate
		for (m = 0; m < NM; m++) begin : g_master
			wire hit_m  = n_hmaster_i == MIDW'(m);
			wire done_m = rd_done & (head_mst == MIDW'(m));
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					outst_reg[m]    <= 1'b0;
					held_vld_reg[m] <= 1'b0;
					n_hsplit_o[m]   <= 1'b0;
				end else begin
					if (do_push & ~n_hwrite_i & hit_m)
						outst_reg[m] <= 1'b1;
					else if (done_m)
						outst_reg[m] <= 1'b0;
					// hold returned data, set wins over collect
					if (done_m)
						held_vld_reg[m] <= 1'b1;
					else if (ok_rd & hit_m)
						held_vld_reg[m] <= 1'b0;
					// tell the arbiter this master may retry
					n_hsplit_o[m] <= done_m;
				end
			end
			always_ff @(posedge clk_sys_i) begin
				// data only goes to its owner
				if (done_m)
					held_data_reg[m] <= s_hrdata_i;
			end
		end
	endgenerate

	// south sequencer
	always_comb begin
		unique case (st_reg)
			S_IDLE: st_next = fifo_empty ? S_IDLE : S_REQ;
			S_REQ: st_next = s_load ? S_ADDR : S_REQ;
			S_ADDR: st_next = s_hready_i ? S_DATA : S_ADDR;
			S_DATA: begin
				if (!s_hready_i)
					st_next = S_DATA;
				else
					st_next = s_resp_end ? S_IDLE : S_REQ;
			end
		endcase
	end

	// request the south bus as soon as work is queued
	// bridge acts as a 32-bit south master
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg      <= S_IDLE;
			s_hbusreq_o <= 1'b0;
			s_htrans_o  <= `HTRANS_IDLE;
			s_haddr_o   <= '0;
			s_hwrite_o  <= 1'b0;
			s_hwdata_o  <= '0;
			s_hsize_o   <= `HSIZE_WORD;
			s_hburst_o  <= `HBURST_SINGLE;
			s_target_o  <= ST_NONE;
			apb_sel_o   <= '0;
		end else begin
			st_reg      <= st_next;
			s_hbusreq_o <= (st_next == S_REQ) | (st_next == S_ADDR);
			s_htrans_o  <= (st_next == S_ADDR) ? `HTRANS_NONSEQ : `HTRANS_IDLE;
			// single word transfers never exceed a burst
			s_hburst_o  <= `HBURST_SINGLE;
			s_hsize_o   <= `HSIZE_WORD;
			if (s_load) begin
				s_haddr_o  <= head_addr;
				s_hwrite_o <= head_wr;
				s_hwdata_o <= head_data;
				s_target_o <= s_tgt_w;
				apb_sel_o  <= apb_sel_w;
			end
		end
	end

	// checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	a_split_two_cycle: assert property (
		do_split |=> (!n_hready_o && n_hresp_o == `HRESP_SPLIT)
			##1 (n_hready_o && n_hresp_o == `HRESP_SPLIT)
	) else $error("split response not two cycles");

	a_retry_when_full: assert property (
		n_take && !space && n_hwrite_i |=> (n_hresp_o == `HRESP_RETRY) ##1 n_hready_o
	) else $error("full queue did not retry");

	a_write_posted_now: assert property (
		n_take && n_hwrite_i && space |=> n_hready_o && n_hresp_o == `HRESP_OKAY
	) else $error("posted write not released at once");

	a_push_has_room: assert property (
		push_pend_reg |-> count_reg < (PW+1)'(DEPTH)
	) else $error("write into a full queue");

	a_split_done_owner: assert property (
		rd_done |=> n_hsplit_o == (NM'(1) << $past(head_mst))
	) else $error("split done raised for wrong master");

	a_split_done_cause: assert property (
		|n_hsplit_o |-> $past(rd_done)
	) else $error("split done without a finished read");

	a_held_data_owner: assert property (
		ok_rd |=> n_hrdata_o == $past(held_sel)
	) else $error("held data returned wrongly");

	a_south_req_prompt: assert property (
		st_reg == S_IDLE && !fifo_empty |=> s_hbusreq_o ##1 s_hbusreq_o
	) else $error("queued transfer not requested");

	a_south_addr_drive: assert property (
		s_load |=> s_htrans_o == `HTRANS_NONSEQ && s_haddr_o == $past(head_addr)
	) else $error("south address phase wrong");

	a_north_sdram_skip: assert property (
		n_addr_ph && !n_is_bridge |=> n_dsel_o == NT_SDRAM && !push_pend_reg
	) else $error("sdram access taken by bridge");

	a_rdata_only_owner: assert property (
		!ok_rd |=> n_hrdata_o == '0
	) else $error("read data shown without a collect");

	a_apb_sel_shape: assert property (
		(s_target_o == ST_APB) ? $onehot(apb_sel_o) : (apb_sel_o == '0)
	) else $error("apb select not one-hot");

	a_split_done_single: assert property (
		$onehot0(n_hsplit_o)
	) else $error("more than one split done line");

	c_write_posted: cover property (do_push && n_hwrite_i);
	c_split_read_done: cover property (rd_done ##[1:20] ok_rd);
	c_retry_full: cover property (do_retry);
	c_south_retried: cover property (st_reg == S_DATA && s_hready_i && !s_resp_end);

endmodule : ahb_post_split_bridge
`default_nettype wire

//--- south_target_model.sv
// behavioural south ahb arbiter and target facing the bridge
`timescale 1ns/10ps
`default_nettype none
module south_target_model (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	// bridge master side
	input  wire logic        hbusreq_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic        hwrite_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        stall_i,
	output var  logic        hgrant_o,
	output var  logic        hready_o,
	output var  logic [1:0]  hresp_o,
	output var  logic [31:0] hrdata_o,
	// last completed write
	output var  logic [31:0] wr_addr_o,
	output var  logic [31:0] wr_data_o
);
	logic        dphase_reg;
	logic        dwrite_reg;
	logic [31:0] daddr_reg;
	logic [31:0] rd_word;
	assign hready_o = 1'b1;
	assign hresp_o  = 2'h0;
	assign rd_word  = {daddr_reg[15:0], daddr_reg[31:16]};
	// read word only in a read data phase, inverted otherwise
	assign hrdata_o = (dphase_reg && !dwrite_reg) ? rd_word : ~rd_word;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hgrant_o   <= 1'b0;
			dphase_reg <= 1'b0;
			dwrite_reg <= 1'b0;
			daddr_reg  <= 32'h0;
			wr_addr_o  <= 32'h0;
			wr_data_o  <= 32'h0;
		end else begin
			// grant withheld while stalled
			hgrant_o   <= hbusreq_i && !stall_i;
			dphase_reg <= htrans_i == 2'h2;
			if (htrans_i == 2'h2) begin
				daddr_reg  <= haddr_i;
				dwrite_reg <= hwrite_i;
			end
			if (dphase_reg && dwrite_reg) begin
				wr_addr_o <= daddr_reg;
				wr_data_o <= hwdata_i;
			end
		end
	end
endmodule : south_target_model
`default_nettype wire

//--- tb.sv
// self-checking bench for the north-to-south bridge
`timescale 1ns/10ps
`default_nettype none
`include "ahb_bridge_cfg.svh"
module tb;
	import ahb_bridge_pkg::*;
	logic          clk_sys_i = 1'b0;
	logic          rst_n_i = 1'b0;
	logic [31:0]   n_haddr_i = 32'h0;
	logic [31:0]   n_hwdata_i = 32'h0;
	logic [1:0]    n_htrans_i = 2'h0;
	logic          n_hwrite_i = 1'b0;
	logic [3:0]    n_hmaster_i = 4'h0;
	logic          stall = 1'b0;
	wire logic     n_hready_i, n_hready_o, s_hgrant_i, s_hready_i, s_hbusreq_o, s_hwrite_o;
	wire logic [1:0]  n_hresp_o, s_hresp_i, s_htrans_o;
	wire logic [31:0] n_hrdata_o, s_hrdata_i, s_haddr_o, s_hwdata_o, wa, wd;
	wire logic [15:0] n_hsplit_o;
	wire logic [2:0]  s_hsize_o, s_hburst_o;
	wire logic [7:0]  apb_sel_o;
	north_target_t    n_dsel_o;
	south_target_t    s_target_o;
	int            err_total = 0;
	int            tests_run = 0;
	logic          r0;
	logic [1:0]    p0, p1;
	logic [31:0]   rd;
	always #2.5 clk_sys_i = ~clk_sys_i;
	assign n_hready_i = n_hready_o;
	ahb_post_split_bridge u_ahb_post_split_bridge (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.n_haddr_i(n_haddr_i), .n_htrans_i(n_htrans_i), .n_hwrite_i(n_hwrite_i), .n_hwdata_i(n_hwdata_i),
		.n_hmaster_i(n_hmaster_i), .n_hready_i(n_hready_i), .n_hready_o(n_hready_o), .n_hresp_o(n_hresp_o),
		.n_hrdata_o(n_hrdata_o), .n_hsplit_o(n_hsplit_o), .n_dsel_o(n_dsel_o), .s_hgrant_i(s_hgrant_i),
		.s_hready_i(s_hready_i), .s_hresp_i(s_hresp_i), .s_hrdata_i(s_hrdata_i), .s_hbusreq_o(s_hbusreq_o),
		.s_htrans_o(s_htrans_o), .s_haddr_o(s_haddr_o), .s_hwrite_o(s_hwrite_o), .s_hwdata_o(s_hwdata_o),
		.s_hsize_o(s_hsize_o), .s_hburst_o(s_hburst_o), .s_target_o(s_target_o), .apb_sel_o(apb_sel_o));
	south_target_model u_south_target_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.hbusreq_i(s_hbusreq_o), .htrans_i(s_htrans_o), .haddr_i(s_haddr_o), .hwrite_i(s_hwrite_o),
		.hwdata_i(s_hwdata_o), .stall_i(stall), .hgrant_o(s_hgrant_i), .hready_o(s_hready_i),
		.hresp_o(s_hresp_i), .hrdata_o(s_hrdata_i), .wr_addr_o(wa), .wr_data_o(wd));
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one north transfer; p1 holds the second cycle of a two-cycle answer
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, input logic [3:0] id);
		@(posedge clk_sys_i);
		n_haddr_i   <= a;
		n_hwrite_i  <= w;
		n_hmaster_i <= id;
		n_htrans_i  <= `HTRANS_NONSEQ;
		@(posedge clk_sys_i);
		n_htrans_i <= `HTRANS_IDLE;
		n_hwdata_i <= d;
		#1;
		r0 = n_hready_o;
		p0 = n_hresp_o;
		rd = n_hrdata_o;
		if (r0 !== 1'b1) begin
			@(posedge clk_sys_i);
			#1;
			p1 = n_hresp_o;
		end
	endtask : xfer
	task automatic wait_split(input int id);
		int n;
		for (n = 0; n < 100 && n_hsplit_o[id] !== 1'b1; n++) begin
			@(posedge clk_sys_i);
			#1;
		end
		chk(32'(n < 100), 32'h1);
		if (n >= 100) conclude();
	endtask : wait_split
	task automatic t_reset();
		#1;
		chk(32'(n_hready_o), 32'h1);
		chk(32'(s_hsize_o), 32'(`HSIZE_WORD));
		chk(32'(s_hburst_o), 32'(`HBURST_SINGLE));
		chk(32'(s_target_o), 32'(ST_NONE));
	endtask : t_reset
	task automatic t_post_split();
		xfer(32'h6000_0010, 1'b1, 32'h1234_5678, 4'h1);
		chk(32'(r0), 32'h1);
		chk(32'(p0), 32'(`HRESP_OKAY));
		chk(32'(n_dsel_o), 32'(NT_BRIDGE));
		xfer(32'hc000_5004, 1'b0, 32'h0, 4'h3);
		chk(32'(r0), 32'h0);
		chk(32'(p0), 32'(`HRESP_SPLIT));
		chk(32'(p1), 32'(`HRESP_SPLIT));
		xfer(32'h4000_0020, 1'b1, 32'h0bad_f00d, 4'h2);
		chk(32'(p0), 32'(`HRESP_OKAY));
		wait_split(3);
		chk(wa, 32'h6000_0010);
		chk(wd, 32'h1234_5678);
		chk(32'(apb_sel_o), 32'h20);
		chk(32'($countones(apb_sel_o)), 32'h1);
		chk(32'(s_target_o), 32'(ST_APB));
		xfer(32'hc000_5004, 1'b0, 32'h0, 4'h3);
		chk(32'(p0), 32'(`HRESP_OKAY));
		chk(rd, 32'h5004_c000);
	endtask : t_post_split
	task automatic t_sdram();
		repeat (8) @(posedge clk_sys_i);
		xfer(32'h0000_0100, 1'b1, 32'h55, 4'h1);
		chk(32'(n_dsel_o), 32'(NT_SDRAM));
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk(32'(s_hbusreq_o), 32'h0);
	endtask : t_sdram
	task automatic t_full();
		int i;
		stall <= 1'b1;
		for (i = 0; i < 4; i++) begin
			xfer(32'h5000_0000 + 32'(i * 4), 1'b1, 32'(i), 4'h2);
			chk(32'(p0), 32'(`HRESP_OKAY));
		end
		xfer(32'h5000_0010, 1'b1, 32'h9, 4'h2);
		chk(32'(r0), 32'h0);
		chk(32'(p0), 32'(`HRESP_RETRY));
		chk(32'(p1), 32'(`HRESP_RETRY));
		stall <= 1'b0;
		for (i = 0; i < 20; i++) begin
			xfer(32'h6000_0000, 1'b0, 32'h0, 4'h4);
			if (p0 !== `HRESP_RETRY) break;
		end
		chk(32'(i < 20), 32'h1);
		chk(32'(p1), 32'(`HRESP_SPLIT));
		wait_split(4);
		chk(wd, 32'h3);
		chk(wa, 32'h5000_000c);
		xfer(32'h6000_0000, 1'b0, 32'h0, 4'h4);
		chk(rd, 32'h0000_6000);
	endtask : t_full
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_post_split();
		t_sdram();
		t_full();
		conclude();
	end
endmodule : tb
`default_nettype wire
